// ### logic/data_space_rom_window_decode.sv
// data-space decoder with paged read-only ROM window and core registers
`timescale 1ns/1ps
module data_space_rom_window_decode (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic [7:0] cpu_addr,
   input wire logic cpu_rd,
   input wire logic cpu_wr,
   input wire logic [dspace_pkg::DATA_W-1:0] cpu_wdata,
   output logic [dspace_pkg::DATA_W-1:0] cpu_rdata,
   output logic cpu_rvalid,
   output logic [dspace_pkg::DATA_W-1:0] accumulator,
   output logic [dspace_pkg::DATA_W-1:0] pointer_reg_first,
   output logic [dspace_pkg::DATA_W-1:0] pointer_reg_second,
   output logic [dspace_pkg::DATA_W-1:0] short_direct_first,
   output logic [dspace_pkg::DATA_W-1:0] short_direct_second,
   output logic [dspace_pkg::ROM_AW-1:0] rom_win_addr,
   input wire logic [dspace_pkg::DATA_W-1:0] rom_win_data,
   output logic per_rd,
   output logic per_wr,
   output logic [7:0] per_addr,
   output dspace_pkg::per_target_t per_target,
   output logic [dspace_pkg::DATA_W-1:0] per_wdata,
   input wire logic [dspace_pkg::DATA_W-1:0] per_rdata,
   input wire logic pc_jump,
   input wire logic pc_call,
   input wire logic pc_ret,
   input wire logic pc_inc,
   input wire logic [dspace_pkg::PC_W-1:0] pc_target,
   output logic [dspace_pkg::PC_W-1:0] program_counter,
   input wire logic readout_fuse,
   input wire logic ext_rd_req,
   input wire logic [dspace_pkg::ROM_AW-1:0] ext_rd_addr,
   output logic [dspace_pkg::DATA_W-1:0] ext_rd_data,
   output logic ext_rd_valid,
   output logic ext_rd_blocked
);
   import dspace_pkg::*;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   logic is_win;
   logic is_ram;
   logic is_core;
   logic is_per;
   logic is_page;
   logic [5:0] ram_idx;
   logic [7:0] core_val;
   per_target_t tgt;
   logic rd_take;
   logic wr_take;

   always_comb begin
      is_win = (cpu_addr >= WIN_LO) && (cpu_addr <= WIN_HI); // [R1]
      is_ram = (cpu_addr >= RAM_LO) && (cpu_addr <= RAM_HI); // [R9]
      is_page = (cpu_addr == ADDR_WIN_PAGE); // [R3]
      is_core = (cpu_addr == ADDR_ACC) || ((cpu_addr >= ADDR_PTR_FIRST) && (cpu_addr <= ADDR_SD_SECOND));
      is_per = (cpu_addr >= PER_LO) && (cpu_addr <= PER_HI) && !is_page;
      ram_idx = 6'(cpu_addr - RAM_LO);
      rd_take = clk_en && cpu_rd && !cpu_wr;
      wr_take = clk_en && cpu_wr;
   end

   always_comb begin
      case (cpu_addr)
         ADDR_PA_DATA: tgt = TGT_PA_DATA; // [R17]
         ADDR_PB_DATA: tgt = TGT_PB_DATA; // [R17]
         ADDR_PA_DIR: tgt = TGT_PA_DIR; // [R17]
         ADDR_PA_OPT: tgt = TGT_PA_OPT; // [R18]
         ADDR_PB_OPT: tgt = TGT_PB_OPT; // [R18]
         ADDR_INT_OPT: tgt = TGT_INT_OPT; // [R19]
         default: tgt = TGT_OTHER;
      endcase
   end

   always_comb begin
      case (cpu_addr)
         ADDR_ACC: core_val = accumulator; // [R10]
         ADDR_PTR_FIRST: core_val = pointer_reg_first; // [R11]
         ADDR_PTR_SECOND: core_val = pointer_reg_second; // [R11]
         ADDR_SD_FIRST: core_val = short_direct_first; // [R13]
         ADDR_SD_SECOND: core_val = short_direct_second; // [R13]
         default: core_val = OPEN_READ;
      endcase
   end

   // ----------------------------------------------------------------
   // core registers in data space
   // ----------------------------------------------------------------
   // any addressing form reaches them, since all arrive as plain accesses
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         accumulator <= CORE_REG_RESET;
         pointer_reg_first <= CORE_REG_RESET;
         pointer_reg_second <= CORE_REG_RESET;
         short_direct_first <= CORE_REG_RESET;
         short_direct_second <= CORE_REG_RESET;
      end else if (wr_take) begin
         case (cpu_addr)
            ADDR_ACC: accumulator <= cpu_wdata; // [R10]
            ADDR_PTR_FIRST: pointer_reg_first <= cpu_wdata; // [R11] [R12]
            ADDR_PTR_SECOND: pointer_reg_second <= cpu_wdata; // [R11] [R12]
            ADDR_SD_FIRST: short_direct_first <= cpu_wdata; // [R13] [R14]
            ADDR_SD_SECOND: short_direct_second <= cpu_wdata; // [R13] [R14]
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // general RAM
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] ram_mem [RAM_BYTES];
   logic [DATA_W-1:0] ram_q_r;

   always_ff @(posedge sys_clk) begin
      if (wr_take && is_ram) begin
         ram_mem[ram_idx] <= cpu_wdata; // [R9]
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ram_q_r <= 8'h00;
      end else if (rd_take && is_ram) begin
         ram_q_r <= ram_mem[ram_idx]; // [R9]
      end
   end

   // ----------------------------------------------------------------
   // window page register: no reset, no read path
   // ----------------------------------------------------------------
   logic [PAGE_W-1:0] page_r;

   always_ff @(posedge sys_clk) begin
      if (wr_take && is_page) begin
         page_r <= cpu_wdata[PAGE_W-1:0]; // [R3] [R6] [R7]
      end
   end

   // ----------------------------------------------------------------
   // readout protection fuse
   // ----------------------------------------------------------------
   logic fuse_s1_r;
   logic fuse_s2_r;
   logic fuse_s3_r;
   logic blown_r;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         fuse_s1_r <= 1'b0;
         fuse_s2_r <= 1'b0;
         fuse_s3_r <= 1'b0;
      end else if (clk_en) begin
         fuse_s1_r <= readout_fuse;
         fuse_s2_r <= fuse_s1_r;
         fuse_s3_r <= fuse_s2_r;
      end
   end

   // sticky: nothing but reset clears it, and a held fuse level sets it again four enabled clocks after reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         blown_r <= 1'b0;
      end else if (clk_en && fuse_s2_r && fuse_s3_r) begin
         blown_r <= 1'b1; // [R20]
      end
   end

   // ----------------------------------------------------------------
   // read pipeline: stage one launches, stage two answers
   // ----------------------------------------------------------------
   read_src_t src_r;
   logic rd1_r;
   logic [7:0] core_q_r;
   logic ext1_r;
   logic win_rd;
   logic ext_take;

   always_comb begin
      win_rd = rd_take && is_win;
      ext_take = clk_en && ext_rd_req && !win_rd;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rom_win_addr <= '0;
      end else if (win_rd) begin
         rom_win_addr <= {page_r, cpu_addr[WIN_BITS-1:0]}; // [R2] [R5]
      end else if (ext_take) begin
         rom_win_addr <= ext_rd_addr;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rd1_r <= 1'b0;
         src_r <= SRC_NONE;
         core_q_r <= OPEN_READ;
      end else if (clk_en) begin
         rd1_r <= rd_take;
         core_q_r <= core_val;
         if (!rd_take) begin
            src_r <= SRC_NONE;
         end else if (is_win) begin
            src_r <= SRC_ROM; // [R1]
         end else if (is_ram) begin
            src_r <= SRC_RAM;
         end else if (is_core) begin
            src_r <= SRC_CORE;
         end else if (is_per && tgt != TGT_INT_OPT) begin
            src_r <= SRC_PER;
         end else begin
            src_r <= SRC_NONE; // [R4] [R19]
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cpu_rvalid <= 1'b0;
         cpu_rdata <= OPEN_READ;
      end else if (clk_en) begin
         cpu_rvalid <= rd1_r;
         case (src_r)
            SRC_ROM: cpu_rdata <= rom_win_data; // [R1]
            SRC_RAM: cpu_rdata <= ram_q_r;
            SRC_CORE: cpu_rdata <= core_q_r;
            SRC_PER: cpu_rdata <= per_rdata;
            default: cpu_rdata <= OPEN_READ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ext1_r <= 1'b0;
         ext_rd_valid <= 1'b0;
         ext_rd_data <= BLOCKED_DATA;
         ext_rd_blocked <= 1'b0;
      end else if (clk_en) begin
         ext1_r <= ext_take;
         ext_rd_valid <= ext1_r;
         ext_rd_blocked <= blown_r;
         // the fuse edge blocks as well, so no byte leaks in the cycle blown_r rises
         ext_rd_data <= (ext1_r && !blown_r && !(fuse_s2_r && fuse_s3_r))
            ? rom_win_data : BLOCKED_DATA; // [R20]
      end
   end

   // ----------------------------------------------------------------
   // peripheral register port
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         per_rd <= 1'b0;
         per_wr <= 1'b0;
         per_addr <= 8'h00;
         per_target <= TGT_OTHER;
         per_wdata <= 8'h00;
      end else if (clk_en) begin
         per_rd <= rd_take && is_per && tgt != TGT_INT_OPT; // [R19]
         per_wr <= wr_take && is_per; // [R22]
         if ((rd_take || wr_take) && is_per) begin
            per_addr <= cpu_addr;
            per_target <= tgt; // [R17] [R18] [R19]
            per_wdata <= cpu_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // program counter and stack
   // ----------------------------------------------------------------
   pc_ctl_if pcif ();

   assign pcif.jump = pc_jump;
   assign pcif.call = pc_call;
   assign pcif.ret = pc_ret;
   assign pcif.inc = pc_inc;
   assign pcif.target = pc_target;
   assign program_counter = pcif.pc; // [R21]

   pc_stack u_pc_stack (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .clk_en(clk_en),
      .ctl(pcif.store)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_window_addr: assert property (win_rd |=> rom_win_addr == {$past(page_r), $past(cpu_addr[5:0])})
      else $error("window ROM address wrong"); // [R5]
   a_window_data: assert property (win_rd ##1 clk_en |=> cpu_rvalid && cpu_rdata == $past(rom_win_data))
      else $error("window read data wrong"); // [R1]
   a_window_wr_ign: assert property (wr_take && is_win |=> $stable(accumulator) && !per_wr
      && $stable(pointer_reg_first) && $stable(short_direct_second))
      else $error("window write changed state"); // [R22]
   a_page_low_bits: assert property (wr_take && is_page |=> page_r == $past(cpu_wdata[6:0]))
      else $error("page register not loaded"); // [R7]
   a_page_no_read: assert property (rd_take && is_page ##1 clk_en |=> cpu_rdata == OPEN_READ)
      else $error("page register read back"); // [R4]
   a_acc_write: assert property (wr_take && cpu_addr == ADDR_ACC |=> accumulator == $past(cpu_wdata))
      else $error("accumulator not written"); // [R10]
   a_ptr_readback: assert property (wr_take && cpu_addr == ADDR_PTR_SECOND ##1
      (rd_take && cpu_addr == ADDR_PTR_SECOND) ##1 clk_en |=> cpu_rdata == $past(cpu_wdata, 3))
      else $error("pointer register readback wrong"); // [R11]
   a_sd_write: assert property (wr_take && cpu_addr == ADDR_SD_FIRST
      |=> short_direct_first == $past(cpu_wdata)) else $error("short-direct not written"); // [R13]
   a_port_route: assert property (wr_take && cpu_addr == ADDR_PA_DIR
      |=> per_wr && per_target == TGT_PA_DIR) else $error("port direction misrouted"); // [R17]
   a_opt_route: assert property (wr_take && cpu_addr == ADDR_PB_OPT
      |=> per_wr && per_target == TGT_PB_OPT) else $error("port option misrouted"); // [R18]
   a_intopt_wo: assert property (rd_take && cpu_addr == ADDR_INT_OPT |=> !per_rd)
      else $error("interrupt option read"); // [R19]
   a_fuse_block: assert property (blown_r && ext_rd_valid |-> ext_rd_data == BLOCKED_DATA)
      else $error("protected ROM leaked"); // [R20]
   a_ram_readback: assert property (wr_take && is_ram ##1 (rd_take && $past(cpu_addr) == cpu_addr)
      ##1 clk_en |=> cpu_rdata == $past(cpu_wdata, 3)) else $error("RAM readback wrong"); // [R9]

   c_window_read: cover property (win_rd ##1 clk_en ##1 cpu_rvalid);
   c_page_then_read: cover property (wr_take && is_page ##[1:4] win_rd);
   c_ext_blocked: cover property (blown_r && ext_rd_valid);
   c_per_write: cover property (per_wr && per_target == TGT_PA_DATA);
endmodule // data_space_rom_window_decode

// ### logic/dspace_pkg.sv
// constants, types and address map of the data-space decoder
// Notes on behaviour
// [R1] data addresses 40h..7Fh read as a window onto program ROM
// [R2] window shows 64 consecutive ROM bytes, any location up to 1FFFh
// [R3] writing the page register at C9h moves the window in 64-byte steps
// [R4] page register is write-only; software never reads or bit-operates it
// [R5] ROM byte address is page register above the low 6 data-address bits
// [R6] reset leaves the page register untouched; software writes it first
// [R7] only page bits 6..0 are stored and used; bit 7 is dropped
// [R8] software avoids page writes in interrupts or keeps a RAM copy first
// [R9] data space holds 60 bytes of read/write RAM
// [R10] 8-bit accumulator is an ordinary data location at FFh
// [R11] the two pointer registers sit at 80h and 81h
// [R12] pointer registers are reachable by every direct addressing form
// [R13] the two short-direct registers sit at 82h and 83h
// [R14] short-direct registers are reachable by direct and bit-direct forms
// [R15] program counter is 12 bits and holds the next fetch location
// [R16] six 12-bit stack levels hold return addresses outside data space
// [R17] C0h, C1h go to port data registers, C4h to port direction
// [R18] CCh and CDh go to the two port option registers
// [R19] C8h goes to the write-only interrupt option register
// [R20] once the protection fuse is blown, external ROM readout is blocked for good; reset clears blown_r, reopening readout until the fuse is resampled
// [R21] program fetch addresses come from the 12-bit program counter
// [R22] writes into the ROM window change nothing
package dspace_pkg;
   localparam int DATA_W = 8;
   localparam int ROM_AW = 13;
   localparam int PAGE_W = 7;
   localparam int WIN_BITS = 6;
   localparam int PC_W = 12;
   localparam int STACK_LEVELS = 6;
   localparam int RAM_BYTES = 60;
   localparam logic [2:0] STACK_FULL = 3'h6;
   localparam logic [PC_W-1:0] RESET_PC = 12'hffe;
   localparam logic [7:0] WIN_LO = 8'h40;
   localparam logic [7:0] WIN_HI = 8'h7f;
   localparam logic [7:0] ADDR_PTR_FIRST = 8'h80;
   localparam logic [7:0] ADDR_PTR_SECOND = 8'h81;
   localparam logic [7:0] ADDR_SD_FIRST = 8'h82;
   localparam logic [7:0] ADDR_SD_SECOND = 8'h83;
   localparam logic [7:0] RAM_LO = 8'h84;
   localparam logic [7:0] RAM_HI = 8'hbf;
   localparam logic [7:0] PER_LO = 8'hc0;
   localparam logic [7:0] PER_HI = 8'hfe;
   localparam logic [7:0] ADDR_PA_DATA = 8'hc0;
   localparam logic [7:0] ADDR_PB_DATA = 8'hc1;
   localparam logic [7:0] ADDR_PA_DIR = 8'hc4;
   localparam logic [7:0] ADDR_INT_OPT = 8'hc8;
   localparam logic [7:0] ADDR_WIN_PAGE = 8'hc9;
   localparam logic [7:0] ADDR_PA_OPT = 8'hcc;
   localparam logic [7:0] ADDR_PB_OPT = 8'hcd;
   localparam logic [7:0] ADDR_ACC = 8'hff;
   localparam logic [7:0] OPEN_READ = 8'hff;
   localparam logic [7:0] CORE_REG_RESET = 8'h00;
   localparam logic [7:0] BLOCKED_DATA = 8'h00;

   typedef enum logic [2:0] {
      TGT_OTHER = 3'b000,
      TGT_PA_DATA = 3'b001,
      TGT_PB_DATA = 3'b010,
      TGT_PA_DIR = 3'b011,
      TGT_PA_OPT = 3'b100,
      TGT_PB_OPT = 3'b101,
      TGT_INT_OPT = 3'b110
   } per_target_t;

   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_ROM = 3'b001,
      SRC_RAM = 3'b010,
      SRC_CORE = 3'b011,
      SRC_PER = 3'b100
   } read_src_t;
endpackage

// ### logic/pc_ctl_if.sv
// sequencing signals between the decoder top and the program counter store
`timescale 1ns/1ps
interface pc_ctl_if;
   logic jump;
   logic call;
   logic ret;
   logic inc;
   logic [11:0] target;
   logic [11:0] pc;
   modport seq (output jump, output call, output ret, output inc, output target, input pc);
   modport store (input jump, input call, input ret, input inc, input target, output pc);
endinterface

// ### logic/pc_stack.sv
// program counter with six-level return stack
`timescale 1ns/1ps
module pc_stack (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic clk_en,
   pc_ctl_if.store ctl
);
   import dspace_pkg::*;

   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] stack_r [STACK_LEVELS];
   logic [2:0] depth_r;

   assign ctl.pc = pc_r;

   // ----------------------------------------------------------------
   // program counter
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         pc_r <= RESET_PC;
      end else if (clk_en) begin
         if (ctl.call || ctl.jump) begin
            pc_r <= ctl.target; // [R15] [R21]
         end else if (ctl.ret && depth_r != 3'h0) begin
            pc_r <= stack_r[0]; // [R16]
         end else if (ctl.inc || ctl.ret) begin
            pc_r <= pc_r + 12'h001; // [R15]
         end
      end
   end

   // ----------------------------------------------------------------
   // stack levels
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         depth_r <= 3'h0;
      end else if (clk_en) begin
         if (ctl.call && depth_r != STACK_FULL) begin
            depth_r <= depth_r + 3'h1;
         end else if (!ctl.call && !ctl.jump && ctl.ret && depth_r != 3'h0) begin
            depth_r <= depth_r - 3'h1;
         end
      end
   end

   for (genvar i = 0; i < STACK_LEVELS; i++) begin : g_level
      always_ff @(posedge sys_clk or negedge rstn) begin
         if (!rstn) begin
            stack_r[i] <= 12'h000;
         end else if (clk_en) begin
            if (ctl.call) begin
               // deepest level is lost on overflow
               stack_r[i] <= (i == 0) ? pc_r : stack_r[(i == 0) ? 0 : i-1]; // [R16]
            end else if (!ctl.jump && ctl.ret && depth_r != 3'h0) begin
               stack_r[i] <= (i == STACK_LEVELS-1) ? stack_r[i] : stack_r[(i == STACK_LEVELS-1) ? i : i+1];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_pc_step: assert property (clk_en && ctl.inc && !ctl.call && !ctl.jump && !ctl.ret
      |=> pc_r == $past(pc_r) + 12'h001) else $error("pc did not step"); // [R15]
   a_call_return: assert property (clk_en && ctl.call && !ctl.jump ##1
      (clk_en && ctl.ret && !ctl.call && !ctl.jump) |=> pc_r == $past(pc_r, 2))
      else $error("return address lost"); // [R16]
   c_call_ret: cover property (clk_en && ctl.call ##1 clk_en && ctl.ret);
endmodule // pc_stack

// ### testbench/rom_per_model.sv
// far-side model: program ROM contents and peripheral read data
`timescale 1ns/1ps
module rom_per_model (
   input wire logic [12:0] rom_win_addr,
   output logic [7:0] rom_win_data,
   input wire logic per_rd,
   input wire logic [7:0] per_addr,
   output logic [7:0] per_rdata
);
   // ------------------------------------------
   // rom pattern and peripheral answer
   // ------------------------------------------
   // every rom byte differs from its neighbours, but bytes of different pages can repeat
   assign rom_win_data = rom_win_addr[7:0] ^ {rom_win_addr[12:8], 3'h0};
   // outside a read the bus shows per_addr itself, never the last answer
   assign per_rdata = per_rd ? ~per_addr : per_addr;
endmodule // rom_per_model

// ### testbench/tb_data_space_rom_window_decode.sv
// self-checking bench for the data-space decoder
`timescale 1ns/1ps
module tb_data_space_rom_window_decode;
   import dspace_pkg::*;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00;
   logic cpu_rd = 1'b0, cpu_wr = 1'b0, pc_jump = 1'b0, pc_call = 1'b0, pc_ret = 1'b0;
   logic readout_fuse = 1'b0, ext_rd_req = 1'b0, clk_en = 1'b1, pc_inc = 1'b0;
   logic [11:0] pc_target = 12'h000;
   logic [12:0] ext_rd_addr = 13'h0000;
   logic [7:0] cpu_rdata, accumulator, pointer_reg_first, pointer_reg_second;
   logic [7:0] short_direct_first, short_direct_second, rom_win_data, per_addr;
   logic [7:0] per_wdata, per_rdata, ext_rd_data, rd_v;
   logic [12:0] rom_win_addr;
   logic [11:0] program_counter;
   logic cpu_rvalid, per_rd, per_wr, ext_rd_valid, ext_rd_blocked;
   per_target_t per_target;
   int bad_count = 0, n_checks = 0, cycles = 0;
   always #2 sys_clk = ~sys_clk;
   // ------------------------------------------
   // design and far side
   // ------------------------------------------
   data_space_rom_window_decode uut (.sys_clk, .rstn, .clk_en, .cpu_addr, .cpu_rd,
      .cpu_wr, .cpu_wdata, .cpu_rdata, .cpu_rvalid, .accumulator, .pointer_reg_first,
      .pointer_reg_second, .short_direct_first, .short_direct_second, .rom_win_addr,
      .rom_win_data, .per_rd, .per_wr, .per_addr, .per_target, .per_wdata, .per_rdata,
      .pc_jump, .pc_call, .pc_ret, .pc_inc, .pc_target, .program_counter,
      .readout_fuse, .ext_rd_req, .ext_rd_addr, .ext_rd_data, .ext_rd_valid,
      .ext_rd_blocked);
   rom_per_model far (.rom_win_addr, .rom_win_data, .per_rd, .per_addr, .per_rdata);
   // ------------------------------------------
   // helpers
   // ------------------------------------------
   function automatic logic [7:0] rom_f(input logic [12:0] a);
      return a[7:0] ^ {a[12:8], 3'h0};
   endfunction
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      cpu_wr = 1'b1;
      cpu_addr = a;
      cpu_wdata = d;
      @(negedge sys_clk);
      cpu_wr = 1'b0;
   endtask
   // read, wait a bounded time for the answer, compare
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      cpu_rd = 1'b1;
      cpu_addr = a;
      @(negedge sys_clk);
      cpu_rd = 1'b0;
      rd_v = 8'hxx;
      for (int i = 0; i < 4; i++) begin
         if (cpu_rvalid === 1'b1) begin
            rd_v = cpu_rdata;
            break;
         end
         @(negedge sys_clk);
      end
      chk(rd_v, exp);
   endtask
   task automatic pc_op(input logic [2:0] op, input logic [11:0] t);
      @(negedge sys_clk);
      {pc_jump, pc_call, pc_ret} = op;
      pc_target = t;
      @(negedge sys_clk);
      {pc_jump, pc_call, pc_ret} = 3'h0;
   endtask
   task automatic ext_rd(input logic [12:0] a, input logic [7:0] exp);
      @(negedge sys_clk);
      ext_rd_req = 1'b1;
      ext_rd_addr = a;
      @(negedge sys_clk);
      ext_rd_req = 1'b0;
      rd_v = 8'hxx;
      for (int i = 0; i < 4; i++) begin
         if (ext_rd_valid === 1'b1) begin
            rd_v = ext_rd_data;
            break;
         end
         @(negedge sys_clk);
      end
      chk(rd_v, exp);
   endtask
   // ------------------------------------------
   // scenarios
   // ------------------------------------------
   task automatic t_pc();
      chk(program_counter, RESET_PC);
      pc_op(3'h4, 12'h100);
      chk(program_counter, 12'h100);
      for (int i = 0; i < 7; i++) pc_op(3'h2, 12'h300 + 12'(i));
      chk(program_counter, 12'h306);
      for (int i = 5; i >= 0; i--) begin
         pc_op(3'h1, 12'h000);
         chk(program_counter, 12'h300 + 12'(i));
      end
      pc_op(3'h1, 12'h000);
      chk(program_counter, 12'h301);
      @(negedge sys_clk);
      pc_inc = 1'b1;
      @(negedge sys_clk);
      pc_inc = 1'b0;
      chk(program_counter, 12'h302);
   endtask
   task automatic t_freeze();
      wr(ADDR_ACC, 8'h11);
      @(negedge sys_clk);
      clk_en = 1'b0;
      wr(ADDR_ACC, 8'h22);
      chk(accumulator, 8'h11);
      @(negedge sys_clk);
      clk_en = 1'b1;
      rc(ADDR_ACC, 8'h11);
   endtask
   task automatic t_regs();
      logic [7:0] a[7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'hff, 8'h84, 8'hbf};
      for (int i = 0; i < 7; i++) wr(a[i], a[i] ^ 8'h5a);
      for (int i = 0; i < 7; i++) rc(a[i], a[i] ^ 8'h5a);
      chk({accumulator, pointer_reg_second}, 16'ha5db);
      chk({short_direct_first, short_direct_second}, 16'hd8d9);
   endtask
   task automatic t_window();
      wr(ADDR_WIN_PAGE, 8'ha8);
      rc(8'h59, rom_f(13'h0a19));
      wr(8'hbe, 8'h7f);
      wr(ADDR_WIN_PAGE, 8'h7f);
      rc(8'h7f, rom_f(13'h1fff));
      rc(8'h40, rom_f(13'h1fc0));
      wr(8'h40, 8'h00);
      rc(8'h40, rom_f(13'h1fc0));
      wr(ADDR_WIN_PAGE, 8'h00);
      rc(8'h7e, rom_f(13'h003e));
   endtask
   task automatic t_refused();
      rc(ADDR_WIN_PAGE, OPEN_READ);
      rc(ADDR_INT_OPT, OPEN_READ);
      rc(8'h10, OPEN_READ);
   endtask
   task automatic t_per();
      logic [7:0] pa[6] = '{8'hc0, 8'hc1, 8'hc4, 8'hcc, 8'hcd, 8'hc8};
      per_target_t pt[6] = '{TGT_PA_DATA, TGT_PB_DATA, TGT_PA_DIR, TGT_PA_OPT, TGT_PB_OPT,
         TGT_INT_OPT};
      for (int i = 0; i < 6; i++) begin
         wr(pa[i], 8'h30 + 8'(i));
         chk({4'(per_wr), 4'(per_target), per_wdata}, {4'h1, 4'(pt[i]), 8'h30 + 8'(i)});
         chk(per_addr, pa[i]);
      end
      rc(ADDR_PB_DATA, 8'h3e);
   endtask
   task automatic t_reset();
      wr(ADDR_WIN_PAGE, 8'h28);
      rc(8'h45, rom_f(13'h0a05));
      @(negedge sys_clk);
      rstn = 1'b0;
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      chk(accumulator, CORE_REG_RESET);
      rc(8'h45, rom_f(13'h0a05));
   endtask
   task automatic t_ext();
      ext_rd(13'h0a19, rom_f(13'h0a19));
      readout_fuse = 1'b1;
      repeat (6) @(negedge sys_clk);
      chk(ext_rd_blocked, 1'b1);
      ext_rd(13'h0a19, BLOCKED_DATA);
   endtask
   // ------------------------------------------
   // sequence and timeout
   // ------------------------------------------
   initial begin
      repeat (6) @(negedge sys_clk);
      rstn = 1'b1;
      t_pc();
      t_regs();
      t_window();
      t_refused();
      t_per();
      t_freeze();
      t_reset();
      t_ext();
      report_and_stop();
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         report_and_stop();
      end
   end
endmodule // tb_data_space_rom_window_decode
